//--- hw/exec_sync_priv_ea_defines.svh
// Constants for the dispatch control and address generation unit
`ifndef EXEC_SYNC_PRIV_EA_DEFINES_SVH
`define EXEC_SYNC_PRIV_EA_DEFINES_SVH

// Reset value of the user mode flag: privileged
`define USER_FLAG_RST 1'b0
// Program interrupt vector offset
`define PROG_VEC 32'h0000_0700
// Instruction length in bytes
`define INSTR_BYTES 32'h0000_0004
// Word alignment mask for branch targets
`define WORD_MASK 32'hffff_fffc
// Address widths
`define EA_W 32
`define VA_W 40
// Default first fetch address after reset
`define RESET_NIA 32'hffff_fffc

`endif

//--- hw/exec_sync_priv_ea_pkg.sv
// Types shared by the dispatch control and address generation unit
package exec_sync_priv_ea_pkg;
	// Instruction classes seen by dispatch
	typedef enum logic [2:0] {
		OP_PLAIN = 3'h0,
		OP_MEM = 3'h1,
		OP_BRANCH = 3'h2,
		OP_SYNC = 3'h3,
		OP_MTMSR = 3'h4,
		OP_CTXSYNC = 3'h5,
		OP_CRBUS = 3'h6
	} op_t;
	// Data address forms
	typedef enum logic [1:0] {EA_BASE = 2'h0, EA_IMM = 2'h1, EA_INDEX = 2'h2} ea_mode_t;
	// Branch target forms
	typedef enum logic [1:0] {BR_REL = 2'h0, BR_ABS = 2'h1, BR_LINK = 2'h2, BR_COUNT = 2'h3} br_mode_t;
	// One decoded instruction from fetch
	typedef struct packed {
		op_t op;
		logic is_priv;
		ea_mode_t eam;
		br_mode_t brm;
		logic br_taken;
		logic [4:0] base_gpr_field;
		logic [15:0] imm;
		logic [25:0] disp;
		logic new_user;
	} instr_t;
	// Register values read for the instruction
	typedef struct packed {
		logic [31:0] base_val;
		logic [31:0] index_val;
		logic [31:0] link_register;
		logic [31:0] count_register;
	} opnd_t;
endpackage

//--- hw/exec_sync_priv_ea_unit.sv
// Dispatch synchronisation, privilege flag and address generation
`timescale 1ns/1ps
`include "exec_sync_priv_ea_defines.svh"

// Notes on behaviour
// - Sync op recognised: stop issuing further instructions
// - Start only after all exceptions reported
// - Barrier and state-register write are execution sync
// - Context sync ops also execution sync
// - Control bus access ordered like memory access
// - Flag 0 privileged, flag 1 user
// - Reset clears user flag to privileged
// - Privileged op in user mode raises exception
// - User mode blocks privileged subset only
// - Effective address is 32-bit unsigned sum
// - Data address: base, base+imm, base+index
// - Base field zero means base value zero
// - Sequential next address is current plus four
// - Branch target: relative, absolute, link, count
// - Branch target low two bits forced zero
// - Carry out discarded, address wraps to zero
// - Physical address is 32 bits
// - Virtual address is 40 bits
// - Separate instruction and data cache ports
module exec_sync_priv_ea_unit import exec_sync_priv_ea_pkg::*; #(
	parameter logic [31:0] RESET_NIA = `RESET_NIA,
	parameter int SPACE_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire instr_t instr,
	input wire opnd_t opnd,
	input wire logic all_reported,
	input wire logic stores_idle,
	input wire logic [SPACE_W-1:0] space_id,
	output logic issue_ready,
	output logic user_mode_flag,
	output logic [31:0] next_instr_addr,
	output logic [31:0] current_instr_addr,
	output logic [31:0] effective_addr,
	output logic [`VA_W-1:0] virt_addr,
	output logic data_req,
	output logic priv_exc,
	output logic [31:0] exc_vector,
	output logic sync_done,
	output logic cr_bus_go
);
	// Width check: space id and effective address must fill the virtual address
	if (SPACE_W + `EA_W != `VA_W) begin : g_bad_width
		$error("space id width does not fill virtual address");
	end

	// Dispatch states, one-hot
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DRAIN = 3'b010,
		ST_EXEC = 3'b100
	} st_t;

	st_t st_ff, nxt_st;
	op_t held_op_ff, nxt_held_op; // Sync op waiting to run
	logic held_user_ff, nxt_held_user; // Flag value a held state write carries
	logic user_ff, nxt_user; // User mode flag
	logic [31:0] nia_ff, nxt_nia; // Fetch address, icache side
	logic [31:0] cia_ff, nxt_cia; // Address of last accepted instruction
	logic [31:0] ea_ff, nxt_ea; // Data address, dcache side
	logic [`VA_W-1:0] va_ff, nxt_va;
	logic dreq_ff, nxt_dreq;
	logic pexc_ff, nxt_pexc;
	logic [31:0] vec_ff, nxt_vec;
	logic sdone_ff, nxt_sdone;
	logic crgo_ff, nxt_crgo;
	logic accept; // Instruction taken this cycle
	logic is_sync; // Instruction needs execution sync
	logic blocked; // Privileged op tried in user mode
	logic [31:0] base; // Base after the zero-field rule
	logic [31:0] off; // Offset chosen by address form
	logic [31:0] tgt; // Branch target before alignment

	// Fetch may only issue while no sync op is pending
	assign issue_ready = (st_ff == ST_RUN);
	assign accept = instr_valid && issue_ready;
	// Barrier, state write, context ops and bus accesses all drain first
	assign is_sync = (instr.op == OP_SYNC) || (instr.op == OP_MTMSR)
		|| (instr.op == OP_CTXSYNC)
		|| (instr.op == OP_CRBUS);
	// Only the privileged subset is refused in user mode
	assign blocked = instr.is_priv && user_ff;

	// Address operands
	always_comb begin
		// Field zero selects a literal zero, not register zero
		base = (instr.base_gpr_field == 5'h00) ? 32'h0000_0000 : opnd.base_val;
		unique case (instr.eam)
			EA_IMM: off = {{16{instr.imm[15]}}, instr.imm};
			EA_INDEX: off = opnd.index_val;
			default: off = 32'h0000_0000;
		endcase
		unique case (instr.brm)
			BR_REL: tgt = nia_ff + {{6{instr.disp[25]}}, instr.disp};
			BR_ABS: tgt = {{6{instr.disp[25]}}, instr.disp};
			BR_LINK: tgt = opnd.link_register;
			BR_COUNT: tgt = opnd.count_register;
		endcase
	end

	// Next-state logic for dispatch, mode and addresses
	always_comb begin
		nxt_st = st_ff;
		nxt_held_op = held_op_ff;
		nxt_held_user = held_user_ff;
		nxt_user = user_ff;
		nxt_nia = nia_ff;
		nxt_cia = cia_ff;
		nxt_ea = ea_ff;
		nxt_va = va_ff;
		nxt_dreq = 1'b0;
		nxt_pexc = 1'b0;
		nxt_vec = vec_ff;
		nxt_sdone = 1'b0;
		nxt_crgo = 1'b0;
		unique case (st_ff)
			ST_RUN: begin
				if (accept) begin
					nxt_cia = nia_ff;
					if (blocked) begin
						// Refused op: no effect, fetch goes to the handler
						nxt_pexc = 1'b1;
						nxt_vec = `PROG_VEC;
						nxt_nia = `PROG_VEC;
					end else if (is_sync) begin
						nxt_st = ST_DRAIN;
						nxt_held_op = instr.op;
						nxt_held_user = instr.new_user;
					end else if (instr.op == OP_BRANCH && instr.br_taken) begin
						nxt_nia = tgt & `WORD_MASK;
					end else begin
						// Sum is cut to 32 bits, so overflow wraps to zero
						nxt_nia = nia_ff + `INSTR_BYTES;
						if (instr.op == OP_MEM) begin
							nxt_ea = base + off;
							nxt_va = {space_id, base + off};
							nxt_dreq = 1'b1;
						end
					end
				end
			end
			ST_DRAIN: begin
				// Wait for older work to report; bus access also waits for stores
				if (all_reported && (held_op_ff != OP_CRBUS || stores_idle)) begin
					nxt_st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// State write lands at completion, before the next context op
				if (held_op_ff == OP_MTMSR) begin
					nxt_user = held_user_ff;
				end
				nxt_crgo = (held_op_ff == OP_CRBUS);
				nxt_sdone = 1'b1;
				nxt_nia = nia_ff + `INSTR_BYTES;
				nxt_st = ST_RUN;
			end
			default: nxt_st = ST_RUN;
		endcase
	end

	// State registers; reset starts privileged at the reset vector
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_RUN;
			held_op_ff <= OP_PLAIN;
			held_user_ff <= 1'b0;
			user_ff <= `USER_FLAG_RST;
			nia_ff <= RESET_NIA;
			cia_ff <= RESET_NIA;
			ea_ff <= 32'h0000_0000;
			va_ff <= '0;
			dreq_ff <= 1'b0;
			pexc_ff <= 1'b0;
			vec_ff <= 32'h0000_0000;
			sdone_ff <= 1'b0;
			crgo_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			held_op_ff <= nxt_held_op;
			held_user_ff <= nxt_held_user;
			user_ff <= nxt_user;
			nia_ff <= nxt_nia;
			cia_ff <= nxt_cia;
			ea_ff <= nxt_ea;
			va_ff <= nxt_va;
			dreq_ff <= nxt_dreq;
			pexc_ff <= nxt_pexc;
			vec_ff <= nxt_vec;
			sdone_ff <= nxt_sdone;
			crgo_ff <= nxt_crgo;
		end
	end

	// Outputs come straight from registers
	assign user_mode_flag = user_ff;
	assign next_instr_addr = nia_ff;
	assign current_instr_addr = cia_ff;
	assign effective_addr = ea_ff;
	assign virt_addr = va_ff;
	assign data_req = dreq_ff;
	assign priv_exc = pexc_ff;
	assign exc_vector = vec_ff;
	assign sync_done = sdone_ff;
	assign cr_bus_go = crgo_ff;

	// Checks
	sequence s_take_sync;
		accept && is_sync && !blocked;
	endsequence
	sequence s_drain_hold;
		(st_ff == ST_DRAIN) && !issue_ready;
	endsequence

	property p_no_issue;
		@(posedge clk) disable iff (rst) (st_ff != ST_RUN) |-> !issue_ready;
	endproperty
	a_no_issue: assert property (p_no_issue) else $error("issue while sync pending");

	property p_wait_report;
		@(posedge clk) disable iff (rst) (st_ff == ST_EXEC) |-> $past(all_reported);
	endproperty
	a_wait_report: assert property (p_wait_report) else $error("sync ran early");

	property p_sync_drain;
		@(posedge clk) disable iff (rst) s_take_sync |=> s_drain_hold;
	endproperty
	a_sync_drain: assert property (p_sync_drain) else $error("sync op not drained");

	property p_bus_order;
		@(posedge clk) disable iff (rst) cr_bus_go |-> $past(stores_idle, 2) && sync_done;
	endproperty
	a_bus_order: assert property (p_bus_order) else $error("bus access unordered");

	property p_msr_write;
		@(posedge clk) disable iff (rst)
			(st_ff == ST_EXEC && held_op_ff == OP_MTMSR) |=> user_ff == $past(held_user_ff);
	endproperty
	a_msr_write: assert property (p_msr_write) else $error("mode write lost");

	property p_reset_priv;
		@(posedge clk) disable iff (rst) $past(rst) |-> !user_ff;
	endproperty
	a_reset_priv: assert property (p_reset_priv) else $error("not privileged after reset");

	property p_priv_exc;
		@(posedge clk) disable iff (rst)
			(accept && instr.is_priv && user_ff) |=> priv_exc && exc_vector == 32'h0000_0700
				&& next_instr_addr == 32'h0000_0700 ##1 !priv_exc;
	endproperty
	a_priv_exc: assert property (p_priv_exc) else $error("missing privilege exception");

	property p_seq_next;
		@(posedge clk) disable iff (rst)
			(accept && !blocked && !is_sync && instr.op != OP_BRANCH)
				|=> nia_ff == $past(nia_ff) + 32'h0000_0004;
	endproperty
	a_seq_next: assert property (p_seq_next) else $error("sequential address wrong");

	property p_align;
		@(posedge clk) disable iff (rst)
			(accept && !blocked && instr.op == OP_BRANCH && instr.br_taken) |=> nia_ff[1:0] == 2'h0;
	endproperty
	a_align: assert property (p_align) else $error("branch target unaligned");

	property p_base_zero;
		@(posedge clk) disable iff (rst)
			(accept && !blocked && instr.op == OP_MEM && instr.eam == EA_BASE
				&& instr.base_gpr_field == 5'h00) |=> ea_ff == 32'h0000_0000 && data_req;
	endproperty
	a_base_zero: assert property (p_base_zero) else $error("zero base not used");

	// A privileged op in privileged mode must never be refused
	property p_priv_ok;
		@(posedge clk) disable iff (rst) (accept && instr.is_priv && !user_ff) |=> !priv_exc;
	endproperty
	a_priv_ok: assert property (p_priv_ok) else $error("privileged op refused");

	// Completion follows the exec state by one cycle and reopens dispatch
	property p_exec_done;
		@(posedge clk) disable iff (rst) (st_ff == ST_EXEC) |=> sync_done && issue_ready;
	endproperty
	a_exec_done: assert property (p_exec_done) else $error("sync did not complete");

	// Virtual address carries the space id taken with the op above the data address
	property p_va_form;
		@(posedge clk) disable iff (rst)
			data_req |-> virt_addr[`EA_W-1:0] == effective_addr
				&& virt_addr[`VA_W-1:`EA_W] == $past(space_id);
	endproperty
	a_va_form: assert property (p_va_form) else $error("virtual address malformed");

	// Each accepted op records the fetch address it came from
	property p_cia_take;
		@(posedge clk) disable iff (rst) accept |=> current_instr_addr == $past(nia_ff);
	endproperty
	a_cia_take: assert property (p_cia_take) else $error("current address wrong");

endmodule // exec_sync_priv_ea_unit

//--- testbench/tb.sv
// Self-checking bench for the dispatch sync, privilege and address unit
`timescale 1ns/1ps
`include "exec_sync_priv_ea_defines.svh"

// Count a comparison and report a mismatch at once
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb import exec_sync_priv_ea_pkg::*; ();
	logic clk = 1'b0; // Bench clock, 50 ns period
	logic rst = 1'b1; // Held for four cycles at start
	logic instr_valid = 1'b0;
	instr_t instr = '0;
	opnd_t opnd = '0;
	logic all_reported = 1'b1; // High unless a scenario wants a drain stall
	logic stores_idle = 1'b1;
	logic [7:0] space_id = 8'h5a; // Fixed space id, checked in the virtual address
	logic issue_ready, user_mode_flag, data_req, priv_exc, sync_done, cr_bus_go;
	logic [31:0] next_instr_addr, current_instr_addr, effective_addr, exc_vector;
	logic [`VA_W-1:0] virt_addr;
	int n_fail = 0;
	int checks = 0;
	logic [31:0] pc; // Address of the next instruction the bench offers

	exec_sync_priv_ea_unit dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .opnd(opnd), .all_reported(all_reported),
		.stores_idle(stores_idle), .space_id(space_id), .issue_ready(issue_ready),
		.user_mode_flag(user_mode_flag), .next_instr_addr(next_instr_addr),
		.current_instr_addr(current_instr_addr), .effective_addr(effective_addr),
		.virt_addr(virt_addr), .data_req(data_req), .priv_exc(priv_exc),
		.exc_vector(exc_vector), .sync_done(sync_done), .cr_bus_go(cr_bus_go));

	// Free-running clock
	initial begin
		forever #25 clk = ~clk;
	end

	// Verdict and end of run, shared by the main flow and timeouts
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Build a decoded instruction in field order
	function automatic instr_t mk(op_t op, logic pv, ea_mode_t em, br_mode_t bm, logic tk,
		logic [4:0] g, logic [15:0] im, logic [25:0] d, logic nu);
		mk = '{op, pv, em, bm, tk, g, im, d, nu};
	endfunction

	// Offer one instruction; it is taken at the second edge, returns settled in c1
	task automatic issue(input instr_t i, input opnd_t o);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= i;
		opnd <= o;
		#1 `CHK("issue_ready", 1'b1, issue_ready)
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	// Data access with a hand-worked expected address
	task automatic mem(ea_mode_t em, logic [4:0] g, logic [15:0] im, logic [31:0] b, x, e);
		issue(mk(OP_MEM, 1'b0, em, BR_REL, 1'b0, g, im, 26'h0, 1'b0), '{b, x, 32'h0, 32'h0});
		`CHK("ea", e, effective_addr)
		`CHK("va", {space_id, e}, virt_addr)
		`CHK("data_req", 1'b1, data_req)
		`CHK("cia", pc, current_instr_addr)
		`CHK("nia", pc + 32'h4, next_instr_addr)
		pc = pc + 32'h4;
		@(posedge clk);
		#1 `CHK("data_req", 1'b0, data_req)
	endtask

	// Branch; target worked out from mode, then word aligned
	task automatic br(br_mode_t bm, logic tk, logic [25:0] d, logic [31:0] lk, ct);
		logic [31:0] sx, e;
		sx = {{6{d[25]}}, d};
		case (bm)
			BR_REL: e = pc + sx;
			BR_ABS: e = sx;
			BR_LINK: e = lk;
			default: e = ct;
		endcase
		// Untaken branches just step on
		e = tk ? (e & 32'hffff_fffc) : pc + 32'h4;
		issue(mk(OP_BRANCH, 1'b0, EA_BASE, bm, tk, 5'h0, 16'h0, d, 1'b0), '{32'h0, 32'h0, lk, ct});
		`CHK("br nia", e, next_instr_addr)
		`CHK("data_req", 1'b0, data_req)
		pc = e;
	endtask

	// Sync-class op held in drain until the bench lets exceptions report
	task automatic sync(op_t op, logic nu);
		int n;
		@(posedge clk);
		all_reported <= 1'b0;
		stores_idle <= 1'b0;
		issue(mk(op, op == OP_MTMSR, EA_BASE, BR_REL, 1'b0, 5'h0, 16'h0, 26'h0, nu), '0);
		repeat (4) begin
			@(posedge clk);
			#1 `CHK("stall", 1'b0, issue_ready)
			`CHK("early done", 1'b0, sync_done)
		end
		@(posedge clk);
		all_reported <= 1'b1;
		stores_idle <= (op != OP_CRBUS);
		// Control bus access must also wait for outstanding stores
		if (op == OP_CRBUS) begin
			repeat (4) begin
				@(posedge clk);
				#1 `CHK("bus wait", 1'b0, sync_done)
			end
			@(posedge clk);
			stores_idle <= 1'b1;
		end
		#1;
		for (n = 0; n < 10 && sync_done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 10) begin
			n_fail++;
			test_done();
		end
		`CHK("resume", 1'b1, issue_ready)
		`CHK("bus go", op == OP_CRBUS, cr_bus_go)
		`CHK("sync nia", pc + 32'h4, next_instr_addr)
		pc = pc + 32'h4;
		@(posedge clk);
		#1 `CHK("mode", nu, user_mode_flag)
		`CHK("done pulse", 1'b0, sync_done)
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1 `CHK("rst mode", 1'b0, user_mode_flag)
		`CHK("rst nia", `RESET_NIA, next_instr_addr)
		pc = `RESET_NIA;
		// First fetch step wraps past the top address
		mem(EA_BASE, 5'h3, 16'h0, 32'h1000_0012, 32'h0, 32'h1000_0012);
		mem(EA_IMM, 5'h3, 16'hfff0, 32'h0000_0100, 32'h0, 32'h0000_00f0);
		mem(EA_INDEX, 5'h0, 16'h0, 32'hdead_beef, 32'h20, 32'h20);
		mem(EA_INDEX, 5'h7, 16'h0, 32'hffff_fff0, 32'h20, 32'h10);
		mem(EA_IMM, 5'h0, 16'h7ffc, 32'h5555_5555, 32'h0, 32'h7ffc);
		br(BR_REL, 1'b1, 26'h3ff_fff8, 32'h0, 32'h0);
		br(BR_ABS, 1'b1, 26'h000_1237, 32'h0, 32'h0);
		br(BR_LINK, 1'b1, 26'h0, 32'h8000_0003, 32'h0);
		br(BR_COUNT, 1'b1, 26'h0, 32'h0, 32'h1234_567a);
		br(BR_COUNT, 1'b0, 26'h0, 32'h0, 32'h1234_567a);
		// Privileged op is allowed in privileged mode
		issue(mk(OP_PLAIN, 1'b1, EA_BASE, BR_REL, 1'b0, 5'h0, 16'h0, 26'h0, 1'b0), '0);
		`CHK("no exc", 1'b0, priv_exc)
		`CHK("priv nia", pc + 32'h4, next_instr_addr)
		pc = pc + 32'h4;
		sync(OP_SYNC, 1'b0);
		sync(OP_CTXSYNC, 1'b0);
		sync(OP_CRBUS, 1'b0);
		sync(OP_MTMSR, 1'b1);
		// User mode refuses the privileged op and vectors away
		issue(mk(OP_PLAIN, 1'b1, EA_BASE, BR_REL, 1'b0, 5'h0, 16'h0, 26'h0, 1'b0), '0);
		`CHK("exc", 1'b1, priv_exc)
		`CHK("vector", `PROG_VEC, exc_vector)
		`CHK("exc nia", `PROG_VEC, next_instr_addr)
		`CHK("still user", 1'b1, user_mode_flag)
		pc = `PROG_VEC;
		@(posedge clk);
		#1 `CHK("exc pulse", 1'b0, priv_exc)
		// Ordinary op still runs in user mode
		mem(EA_IMM, 5'h0, 16'h8000, 32'h0, 32'h0, 32'hffff_8000);
		// Second reset in mid-run returns to privileged mode
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1 `CHK("rst2 mode", 1'b0, user_mode_flag)
		`CHK("rst2 nia", `RESET_NIA, next_instr_addr)
		@(posedge clk);
		rst <= 1'b0;
		test_done();
	end
endmodule // tb
